/* obcd_defines.vh */
/*
 header of constants for the configuration byte decoder: field positions,
 factory default values, encodings and the program memory size.
 assumes it is included by its bare name from the design files.
*/
`ifndef OBCD_DEFINES_VH
`define OBCD_DEFINES_VH

// ----------------------------------------------------------------------
// configuration byte indexes
// ----------------------------------------------------------------------
`define OBCD_IDX_MEMPROT        1'h0
`define OBCD_IDX_CLKSUP         1'h1

// ----------------------------------------------------------------------
// memory protection byte fields
// ----------------------------------------------------------------------
`define OBCD_B0_RSVD_HI         7
`define OBCD_B0_RSVD_LO         4
`define OBCD_B0_SEC_HI          3
`define OBCD_B0_SEC_LO          2
`define OBCD_B0_RDP             1
`define OBCD_B0_WRP             0

// ----------------------------------------------------------------------
// clock and supervisor byte fields
// ----------------------------------------------------------------------
`define OBCD_B1_PLLX8           7
`define OBCD_B1_PLLBYP          6
`define OBCD_B1_RSVD            5
`define OBCD_B1_RCOFF           4
`define OBCD_B1_LVD_HI          3
`define OBCD_B1_LVD_LO          2
`define OBCD_B1_WDGSW           1
`define OBCD_B1_WDGHALT         0

// ----------------------------------------------------------------------
// factory default values
// ----------------------------------------------------------------------
`define OBCD_B0_DEFAULT         8'hFC
`define OBCD_B1_DEFAULT         8'hEF
`define OBCD_RSVD_ONES          8'hF0
`define OBCD_B1_RSVD_ONE        8'h20
`define OBCD_ERASED_BYTE        8'hFF

// ----------------------------------------------------------------------
// decoded encodings
// ----------------------------------------------------------------------
`define OBCD_SEC_0K5            2'h0
`define OBCD_SEC_1K             2'h1
`define OBCD_SEC_1K5            2'h2
`define OBCD_LVD_OFF            2'h3
`define OBCD_LVD_HIGH           2'h2
`define OBCD_LVD_MED            2'h1
`define OBCD_LVD_LOW            2'h0
`define OBCD_PLL_X4             2'h0
`define OBCD_PLL_X8             2'h1
`define OBCD_PLL_OFF            2'h2

// ----------------------------------------------------------------------
// program memory size, in bytes
// ----------------------------------------------------------------------
`define OBCD_MEM_DEPTH          1536
`define OBCD_MEM_AW             11

`endif

/* obcd_store.v */
/*
 small non-volatile store model for the two configuration bytes: one write
 port, one registered read port, a whole erase that restores factory values.
 assumes the caller arbitrates access and only raises one strobe at a time.
*/
`timescale 1ns/1ps
`include "obcd_defines.vh"

module obcd_store (
   input  wire       i_sys_clk,
   input  wire       i_sys_rst,
   input  wire       i_ce,
   input  wire       i_wr,
   input  wire       i_erase,
   input  wire       i_idx,
   input  wire [7:0] i_wdata,
   input  wire       i_rd_idx,
   output reg  [7:0] o_rdata
);

   reg [7:0] mem_r [0:1];

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   // contents survive the logic reset, as a non-volatile cell would
   initial begin
      mem_r[0] = `OBCD_B0_DEFAULT;
      mem_r[1] = `OBCD_B1_DEFAULT;
   end

   always @(posedge i_sys_clk) begin
      if (i_ce) begin
         if (i_erase) begin
            mem_r[0] <= `OBCD_B0_DEFAULT;
            mem_r[1] <= `OBCD_B1_DEFAULT;
         end else if (i_wr) begin
            mem_r[i_idx] <= i_wdata;
         end
      end
   end

   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_rdata <= 8'h00;
      end else if (i_ce) begin
         o_rdata <= mem_r[i_rd_idx];
      end
   end

endmodule

/* obcd_decoder.v */
/*
 configuration byte loader and decoder: holds the two configuration bytes,
 lets a programmer reach them and the program memory in programming mode,
 loads them after reset and drives the decoded settings as static levels.
 assumes a single clock, synchronous inputs and a programmer that follows
 the access ports below.
*/
// Function
// - sector size 00 half k, 01 one k, 1x one and half k
// - read-out protection set blocks memory reads and flash writes
// - erasing config bytes under read-out protection erases whole memory first
// - write protection set refuses any erase or program, permanently
// - bypass bit 1 bypasses pll; else factor bit picks x4 or x8
// - oscillator bit 0 runs internal rc, 1 takes external clock
// - low voltage field 11 off, 10 high, 01 medium, 00 low threshold
// - watchdog bit 0 always on, 1 waits for software enable
// - halt reset bit 1 with active watchdog resets on halt entry
// - configuration bytes accessible only in programming mode
// - parts ship with memory all FFh and oscillator bit zero
`timescale 1ns/1ps
`include "obcd_defines.vh"

module obcd_decoder #(
   parameter MEM_DEPTH = `OBCD_MEM_DEPTH,
   parameter MEM_AW    = `OBCD_MEM_AW
) (
   input  wire              i_sys_clk,
   input  wire              i_sys_rst,
   input  wire              i_ce,
   input  wire              i_prog_mode,
   input  wire              i_cfg_wr,
   input  wire              i_cfg_rd,
   input  wire              i_cfg_erase,
   input  wire              i_cfg_idx,
   input  wire [7:0]        i_cfg_wdata,
   output reg  [7:0]        o_cfg_rdata,
   output reg               o_cfg_rvalid,
   output wire              o_cfg_refused,
   input  wire              i_mem_wr,
   input  wire              i_mem_rd,
   input  wire [MEM_AW-1:0] i_mem_addr,
   input  wire [7:0]        i_mem_wdata,
   output reg  [7:0]        o_mem_rdata,
   output reg               o_mem_rvalid,
   output wire              o_mem_refused,
   output wire              o_busy,
   input  wire              i_watchdog_activation_sel_enable,
   input  wire              i_halt_entry,
   output reg  [1:0]        o_sector0_size_sel,
   output reg               o_readout_protect,
   output reg               o_flash_write_protect,
   output reg  [1:0]        o_pll_mode,
   output reg               o_pll_factor_sel,
   output reg               o_pll_bypass,
   output reg               o_rc_source_disable,
   output reg               o_rc_osc_enable,
   output reg  [1:0]        o_low_voltage_detect_sel,
   output reg               o_lvd_enable,
   output reg               o_watchdog_activation_sel,
   output wire              o_watchdog_active,
   output reg               o_watchdog_halt_reset,
   output wire              o_halt_reset_req
);

   // ----------------------------------------------------------------------
   // states and decode functions
   // ----------------------------------------------------------------------
   localparam [2:0] ST_LOAD0 = 3'h0;
   localparam [2:0] ST_LOAD1 = 3'h1;
   localparam [2:0] ST_LOAD2 = 3'h2;
   localparam [2:0] ST_RUN   = 3'h3;
   localparam [2:0] ST_WIPE  = 3'h4;

   function [1:0] sec_dec;
      input [1:0] f;
      begin
         if (f[1])
            sec_dec = `OBCD_SEC_1K5;
         else
            sec_dec = f[0] ? `OBCD_SEC_1K : `OBCD_SEC_0K5;
      end
   endfunction

   function [1:0] pll_dec;
      input byp;
      input x8;
      begin
         if (byp)
            pll_dec = `OBCD_PLL_OFF;
         else
            pll_dec = x8 ? `OBCD_PLL_X8 : `OBCD_PLL_X4;
      end
   endfunction

   reg  [2:0]        state_r;
   reg  [2:0]        state_nxt;
   reg  [7:0]        byte0_r;
   reg  [MEM_AW-1:0] wipe_addr_r;
   reg               watchdog_activation_sel_on_r;
   reg  [7:0]        pmem_r [0:MEM_DEPTH-1];
   integer           k;

   wire [7:0] store_rdata;
   wire       running   = (state_r == ST_RUN);
   wire       access_ok = running & i_prog_mode;
   wire       wrp       = o_flash_write_protect;
   wire       rdp       = o_readout_protect;
   // write protection freezes the bytes forever, erase included
   wire       cfg_wr_ok    = access_ok & i_cfg_wr & ~wrp & ~i_cfg_erase;
   wire       cfg_erase_ok = access_ok & i_cfg_erase & ~wrp;
   wire       cfg_rd_ok    = access_ok & i_cfg_rd;
   wire       mem_wr_ok    = access_ok & i_mem_wr & ~wrp & ~rdp;
   wire       mem_rd_ok    = access_ok & i_mem_rd & ~rdp;
   wire       wipe_done    = (wipe_addr_r == MEM_DEPTH - 1);
   wire       store_erase  = i_ce & cfg_erase_ok & ~rdp;
   wire       store_wr     = (state_r == ST_WIPE) & wipe_done;
   wire       wr_now       = cfg_wr_ok | store_erase;

   assign o_busy        = ~running;
   assign o_cfg_refused = (i_cfg_wr | i_cfg_rd | i_cfg_erase) &
                          ~(cfg_wr_ok | cfg_rd_ok | cfg_erase_ok);
   assign o_mem_refused = (i_mem_wr | i_mem_rd) & ~(mem_wr_ok | mem_rd_ok);

   // ----------------------------------------------------------------------
   // byte store
   // ----------------------------------------------------------------------
   // a wipe restores factory bytes on the same edge that clears the last memory byte
   obcd_store u_store (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .i_ce      (i_ce),
      .i_wr      (cfg_wr_ok),
      .i_erase   (store_erase | store_wr),
      .i_idx     (i_cfg_idx),
      .i_wdata   (i_cfg_wdata),
      .i_rd_idx  ((state_r == ST_LOAD0) ? `OBCD_IDX_MEMPROT :
                  (state_r == ST_LOAD1) ? `OBCD_IDX_CLKSUP : i_cfg_idx),
      .o_rdata   (store_rdata)
   );

   // ----------------------------------------------------------------------
   // load sequence
   // ----------------------------------------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_LOAD0: state_nxt = ST_LOAD1;
         ST_LOAD1: state_nxt = ST_LOAD2;
         ST_LOAD2: state_nxt = ST_RUN;
         ST_RUN: begin
            if (cfg_erase_ok & rdp)
               state_nxt = ST_WIPE;
         end
         ST_WIPE: begin
            if (wipe_done)
               state_nxt = ST_RUN;
         end
         default: state_nxt = ST_LOAD0;
      endcase
   end

   // decoded settings change only in load states, so they stay static
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state_r                   <= ST_LOAD0;
         byte0_r                   <= 8'h00;
         wipe_addr_r               <= {MEM_AW{1'b0}};
         o_sector0_size_sel        <= `OBCD_SEC_0K5;
         o_readout_protect         <= 1'b1;
         o_flash_write_protect     <= 1'b1;
         o_pll_mode                <= `OBCD_PLL_OFF;
         o_pll_factor_sel          <= 1'b0;
         o_pll_bypass              <= 1'b1;
         o_rc_source_disable       <= 1'b0;
         o_rc_osc_enable           <= 1'b1;
         o_low_voltage_detect_sel  <= `OBCD_LVD_OFF;
         o_lvd_enable              <= 1'b0;
         o_watchdog_activation_sel <= 1'b0;
         o_watchdog_halt_reset     <= 1'b0;
      end else if (i_ce) begin
         state_r <= state_nxt;
         if (state_r == ST_LOAD1)
            byte0_r <= store_rdata;
         if (state_r == ST_LOAD2) begin
            o_sector0_size_sel    <= sec_dec(byte0_r[`OBCD_B0_SEC_HI:`OBCD_B0_SEC_LO]);
            o_readout_protect     <= byte0_r[`OBCD_B0_RDP];
            o_flash_write_protect <= byte0_r[`OBCD_B0_WRP];
            o_pll_factor_sel      <= store_rdata[`OBCD_B1_PLLX8];
            o_pll_bypass          <= store_rdata[`OBCD_B1_PLLBYP];
            o_pll_mode            <= pll_dec(store_rdata[`OBCD_B1_PLLBYP],
                                             store_rdata[`OBCD_B1_PLLX8]);
            o_rc_source_disable   <= store_rdata[`OBCD_B1_RCOFF];
            o_rc_osc_enable       <= ~store_rdata[`OBCD_B1_RCOFF];
            o_low_voltage_detect_sel <= store_rdata[`OBCD_B1_LVD_HI:`OBCD_B1_LVD_LO];
            o_lvd_enable          <= (store_rdata[`OBCD_B1_LVD_HI:`OBCD_B1_LVD_LO]
                                      != `OBCD_LVD_OFF);
            o_watchdog_activation_sel <= store_rdata[`OBCD_B1_WDGSW];
            o_watchdog_halt_reset <= store_rdata[`OBCD_B1_WDGHALT];
         end
         if (state_r == ST_WIPE)
            wipe_addr_r <= wipe_done ? {MEM_AW{1'b0}} : wipe_addr_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // watchdog activation and halt reset
   // ----------------------------------------------------------------------
   always @(posedge i_sys_clk) begin
      if (i_sys_rst)
         watchdog_activation_sel_on_r <= 1'b0;
      else if (i_ce & running & i_watchdog_activation_sel_enable)
         watchdog_activation_sel_on_r <= 1'b1;
   end

   assign o_watchdog_active = running & (~o_watchdog_activation_sel | watchdog_activation_sel_on_r);
   assign o_halt_reset_req  = i_halt_entry & o_watchdog_active & o_watchdog_halt_reset;

   // ----------------------------------------------------------------------
   // program memory and access answers
   // ----------------------------------------------------------------------
   // shipped blank, every byte erased
   initial begin
      for (k = 0; k < MEM_DEPTH; k = k + 1)
         pmem_r[k] = `OBCD_ERASED_BYTE;
   end

   always @(posedge i_sys_clk) begin
      if (i_ce) begin
         if (state_r == ST_WIPE)
            pmem_r[wipe_addr_r] <= `OBCD_ERASED_BYTE;
         else if (mem_wr_ok)
            pmem_r[i_mem_addr] <= i_mem_wdata;
      end
   end

   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_mem_rdata  <= 8'h00;
         o_mem_rvalid <= 1'b0;
         o_cfg_rvalid <= 1'b0;
         o_cfg_rdata  <= 8'h00;
      end else if (i_ce) begin
         o_mem_rvalid <= mem_rd_ok;
         o_mem_rdata  <= mem_rd_ok ? pmem_r[i_mem_addr] : 8'h00;
         o_cfg_rvalid <= 1'b0;
         if (cfg_rd_ok & ~wr_now)
            o_cfg_rvalid <= 1'b1;
         if (o_cfg_rvalid)
            o_cfg_rdata <= store_rdata;
      end
   end

endmodule

/* obcd_monitor.sv */
/*
 checker for the configuration byte decoder, bound to its top module.
 assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module obcd_monitor #(
   parameter MEM_DEPTH = 1536,
   parameter MEM_AW    = 11
) (
   input wire       i_sys_clk,
   input wire       i_sys_rst,
   input wire       i_ce,
   input wire       i_prog_mode,
   input wire       i_cfg_wr,
   input wire       i_cfg_rd,
   input wire       i_cfg_erase,
   input wire       i_mem_rd,
   input wire       i_halt_entry,
   input wire       o_cfg_refused,
   input wire       o_mem_refused,
   input wire       o_busy,
   input wire       o_readout_protect,
   input wire       o_flash_write_protect,
   input wire [1:0] o_pll_mode,
   input wire       o_pll_factor_sel,
   input wire       o_pll_bypass,
   input wire       o_rc_source_disable,
   input wire       o_rc_osc_enable,
   input wire [1:0] o_low_voltage_detect_sel,
   input wire       o_lvd_enable,
   input wire       o_watchdog_activation_sel,
   input wire       o_watchdog_active,
   input wire       o_watchdog_halt_reset,
   input wire       o_halt_reset_req
);
   wire ok = i_ce && !o_busy;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   property p_pll; !o_busy |-> o_pll_mode == (o_pll_bypass ? 2'h2 : {1'b0, o_pll_factor_sel});
   endproperty
   a_pll: assert property (p_pll) else $error("pll mode");
   property p_rc; o_rc_osc_enable != o_rc_source_disable; endproperty
   a_rc: assert property (p_rc) else $error("rc enable");
   property p_lvd; !o_busy |-> o_lvd_enable == (o_low_voltage_detect_sel != 2'h3); endproperty
   a_lvd: assert property (p_lvd) else $error("lvd enable");
   property p_halt;
      o_halt_reset_req == (i_halt_entry && o_watchdog_active && o_watchdog_halt_reset);
   endproperty
   a_halt: assert property (p_halt) else $error("halt reset");
   property p_wdg; !o_busy && !o_watchdog_activation_sel |-> o_watchdog_active; endproperty
   a_wdg: assert property (p_wdg) else $error("watchdog off");
   property p_mode; ok && !i_prog_mode && (i_cfg_wr || i_cfg_rd) |-> o_cfg_refused; endproperty
   a_mode: assert property (p_mode) else $error("cfg outside prog");
   property p_rdp; ok && i_mem_rd && o_readout_protect |-> o_mem_refused; endproperty
   a_rdp: assert property (p_rdp) else $error("protected read");
   property p_wrp; ok && o_flash_write_protect && (i_cfg_wr || i_cfg_erase) |-> o_cfg_refused;
   endproperty
   a_wrp: assert property (p_wrp) else $error("write protect");
   property p_wipe;
      ok && i_prog_mode && i_cfg_erase && o_readout_protect && !o_flash_write_protect
      |=> o_busy [*8];
   endproperty
   a_wipe: assert property (p_wipe) else $error("wipe");
   property p_hold; !o_busy && !$past(o_busy)
      |-> $stable({o_pll_mode, o_rc_osc_enable, o_lvd_enable, o_readout_protect});
   endproperty
   a_hold: assert property (p_hold) else $error("settings moved");
endmodule

bind obcd_decoder obcd_monitor #(.MEM_DEPTH(MEM_DEPTH), .MEM_AW(MEM_AW)) u_mon (
   .i_sys_clk, .i_sys_rst, .i_ce, .i_prog_mode, .i_cfg_wr, .i_cfg_rd, .i_cfg_erase,
   .i_mem_rd, .i_halt_entry, .o_cfg_refused, .o_mem_refused, .o_busy, .o_readout_protect,
   .o_flash_write_protect, .o_pll_mode, .o_pll_factor_sel, .o_pll_bypass,
   .o_rc_source_disable, .o_rc_osc_enable, .o_low_voltage_detect_sel, .o_lvd_enable,
   .o_watchdog_activation_sel, .o_watchdog_active, .o_watchdog_halt_reset, .o_halt_reset_req);

/* obcd_prog_tool.sv */
/*
 programming tool model: config byte and program memory requests.
 assumes one-cycle request pulses taken at the next rising edge.
*/
`timescale 1ns/1ps
module obcd_prog_tool #(
   parameter AW = 4
) (
   input  wire           i_sys_clk,
   input  wire [7:0]     i_cfg_rdata,
   input  wire           i_cfg_rvalid,
   input  wire           i_cfg_refused,
   input  wire [7:0]     i_mem_rdata,
   input  wire           i_mem_refused,
   output logic          o_prog_mode,
   output logic          o_cfg_wr,
   output logic          o_cfg_rd,
   output logic          o_cfg_erase,
   output logic          o_cfg_idx,
   output logic [7:0]    o_cfg_wdata,
   output logic          o_mem_wr,
   output logic          o_mem_rd,
   output logic [AW-1:0] o_mem_addr,
   output logic [7:0]    o_mem_wdata
);
   // answer strobe seen one edge after the request, kept for the bench to judge
   logic cfg_rv_seen;
   initial begin
      cfg_rv_seen = 1'b0;
      o_prog_mode = 1'b1;
      {o_cfg_wr, o_cfg_rd, o_cfg_erase, o_mem_wr, o_mem_rd} = 5'h00;
      o_cfg_idx = 1'b0;
      o_cfg_wdata = 8'h00;
      o_mem_addr = '0;
      o_mem_wdata = 8'h00;
   end
   task automatic set_prog(input logic v);
      o_prog_mode = v;
   endtask
   // kind 0 cfg write, 1 cfg read, 2 cfg erase, 3 mem write, 4 mem read
   task automatic xfer(input int k, input logic [AW-1:0] a, input logic [7:0] d,
                       output logic rf, output logic [7:0] rd);
      @(posedge i_sys_clk);
      #1;
      {o_cfg_wr, o_cfg_rd, o_cfg_erase, o_mem_wr, o_mem_rd} = 5'h10 >> k;
      o_cfg_idx = a[0];
      o_cfg_wdata = d | (a[0] ? 8'h20 : 8'hF0);
      o_mem_addr = a;
      o_mem_wdata = d;
      #1 rf = (k < 3) ? i_cfg_refused : i_mem_refused;
      @(posedge i_sys_clk);
      #1;
      {o_cfg_wr, o_cfg_rd, o_cfg_erase, o_mem_wr, o_mem_rd} = 5'h00;
      rd = i_mem_rdata;
      cfg_rv_seen = i_cfg_rvalid;
      if (k == 1) begin
         @(posedge i_sys_clk);
         #1 rd = i_cfg_rdata;
      end
      // released data lines turn over so stale values are never mistaken for fresh
      o_cfg_wdata = ~o_cfg_wdata;
      o_mem_wdata = ~o_mem_wdata;
   endtask
endmodule

/* tb.sv */
/*
 self-checking bench for the configuration byte decoder.
 assumes the tool model drives the access ports and the checker is bound.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module tb;
   localparam AW = 4;
   logic i_sys_clk, i_sys_rst, i_ce, i_watchdog_activation_sel_enable, i_halt_entry, rf;
   logic [7:0] rd, b0, b1;
   logic [15:0] seed;
   int n_errors, total_checks;
   wire i_prog_mode, i_cfg_wr, i_cfg_rd, i_cfg_erase, i_cfg_idx, i_mem_wr, i_mem_rd;
   wire [7:0] i_cfg_wdata, o_cfg_rdata, i_mem_wdata, o_mem_rdata;
   wire [AW-1:0] i_mem_addr;
   wire [1:0] o_sector0_size_sel, o_pll_mode, o_low_voltage_detect_sel;
   wire o_cfg_rvalid, o_cfg_refused, o_mem_rvalid, o_mem_refused, o_busy, o_readout_protect;
   wire o_flash_write_protect, o_pll_factor_sel, o_pll_bypass, o_rc_source_disable;
   wire o_rc_osc_enable, o_lvd_enable, o_watchdog_activation_sel, o_watchdog_active;
   wire o_watchdog_halt_reset, o_halt_reset_req;
   wire [14:0] got = {o_sector0_size_sel, o_readout_protect, o_flash_write_protect,
      o_pll_mode, o_pll_factor_sel, o_pll_bypass, o_rc_source_disable, o_rc_osc_enable,
      o_low_voltage_detect_sel, o_lvd_enable, o_watchdog_activation_sel, o_watchdog_halt_reset};
   obcd_decoder #(.MEM_DEPTH(16), .MEM_AW(AW)) DUT (
      .i_sys_clk, .i_sys_rst, .i_ce, .i_prog_mode, .i_cfg_wr, .i_cfg_rd, .i_cfg_erase,
      .i_cfg_idx, .i_cfg_wdata, .o_cfg_rdata, .o_cfg_rvalid, .o_cfg_refused, .i_mem_wr,
      .i_mem_rd, .i_mem_addr, .i_mem_wdata, .o_mem_rdata, .o_mem_rvalid, .o_mem_refused,
      .o_busy, .i_watchdog_activation_sel_enable, .i_halt_entry, .o_sector0_size_sel, .o_readout_protect,
      .o_flash_write_protect, .o_pll_mode, .o_pll_factor_sel, .o_pll_bypass,
      .o_rc_source_disable, .o_rc_osc_enable, .o_low_voltage_detect_sel, .o_lvd_enable,
      .o_watchdog_activation_sel, .o_watchdog_active, .o_watchdog_halt_reset,
      .o_halt_reset_req);
   obcd_prog_tool #(.AW(AW)) u_tool (.i_sys_clk(i_sys_clk), .i_cfg_rdata(o_cfg_rdata),
      .i_cfg_rvalid(o_cfg_rvalid),
      .i_cfg_refused(o_cfg_refused), .i_mem_rdata(o_mem_rdata),
      .i_mem_refused(o_mem_refused), .o_prog_mode(i_prog_mode), .o_cfg_wr(i_cfg_wr),
      .o_cfg_rd(i_cfg_rd), .o_cfg_erase(i_cfg_erase), .o_cfg_idx(i_cfg_idx),
      .o_cfg_wdata(i_cfg_wdata), .o_mem_wr(i_mem_wr), .o_mem_rd(i_mem_rd),
      .o_mem_addr(i_mem_addr), .o_mem_wdata(i_mem_wdata));
   function automatic logic [14:0] dec(input logic [7:0] c0, input logic [7:0] c1);
      dec = {c0[3] ? 2'h2 : {1'b0, c0[2]}, c0[1:0], c1[6] ? 2'h2 : {1'b0, c1[7]}, c1[7:6],
             c1[4], ~c1[4], c1[3:2], c1[3:2] != 2'h3, c1[1:0]};
   endfunction
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // new settings only reach the outputs through a reset and reload
   task automatic reload();
      i_sys_rst = 1'b1;
      repeat (16) @(posedge i_sys_clk);
      #1 i_sys_rst = 1'b0;
      repeat (4) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic prog(input logic [7:0] c0, input logic [7:0] c1);
      u_tool.xfer(0, 0, c0, rf, rd);
      u_tool.xfer(0, 1, c1, rf, rd);
      u_tool.xfer(1, 0, 8'h00, rf, rd);
      `CHK(rd, c0)
      `CHK(u_tool.cfg_rv_seen, 1'b1)
      u_tool.xfer(1, 1, 8'h00, rf, rd);
      `CHK(rd, c1)
      reload();
      `CHK(got, dec(c0, c1))
   endtask
   task automatic halt(input logic e);
      @(posedge i_sys_clk);
      #1 i_halt_entry = 1'b1;
      #1 `CHK(o_halt_reset_req, e)
      @(posedge i_sys_clk);
      #1 i_halt_entry = 1'b0;
   endtask
   initial begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      #100000;
      n_errors++;
      summarize();
   end
   initial begin
      {i_ce, i_watchdog_activation_sel_enable, i_halt_entry, n_errors, total_checks} = {3'h4, 64'h0};
      seed = 16'hE553;
      reload();
      `CHK(got, dec(8'hFC, 8'hEF))
      u_tool.xfer(4, 5, 8'h00, rf, rd);
      `CHK(rd, 8'hFF)
      u_tool.set_prog(1'b0);
      u_tool.xfer(1, 0, 8'h00, rf, rd);
      `CHK(rf, 1'b1)
      `CHK(u_tool.cfg_rv_seen, 1'b0)
      u_tool.set_prog(1'b1);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         b0 = {4'hF, seed[3:1], 1'b0};
         seed = lfsr(seed);
         b1 = {seed[6] | seed[7], seed[6], 1'b1, seed[4] & (seed[6] | seed[7]), seed[3:0]};
         prog(b0, b1);
         u_tool.xfer(3, seed[AW-1:0], b1, rf, rd);
         u_tool.xfer(4, seed[AW-1:0], 8'h00, rf, rd);
         `CHK(rf, b0[1])
         `CHK(o_mem_rvalid, !b0[1])
         if (!b0[1])
            `CHK(rd, b1)
      end
      prog(8'hF4, 8'h20);
      u_tool.xfer(3, 3, 8'h5A, rf, rd);
      // unprotected erase restores the factory bytes at once
      u_tool.xfer(2, 0, 8'h00, rf, rd);
      u_tool.xfer(1, 1, 8'h00, rf, rd);
      `CHK(rd, 8'hEF)
      prog(8'hF2, 8'hE5);
      u_tool.xfer(4, 3, 8'h00, rf, rd);
      `CHK(rf, 1'b1)
      halt(1'b1);
      u_tool.xfer(2, 0, 8'h00, rf, rd);
      `CHK(o_busy, 1'b1)
      for (int n = 0; n < 100 && o_busy === 1'b1; n++) begin
         @(posedge i_sys_clk);
         #1;
      end
      reload();
      `CHK(got, dec(8'hFC, 8'hEF))
      u_tool.xfer(4, 3, 8'h00, rf, rd);
      `CHK(rd, 8'hFF)
      halt(1'b0);
      `CHK(o_watchdog_active, 1'b0)
      i_watchdog_activation_sel_enable = 1'b1;
      @(posedge i_sys_clk);
      #1 i_watchdog_activation_sel_enable = 1'b0;
      `CHK(o_watchdog_active, 1'b1)
      halt(1'b1);
      prog(8'hF1, 8'hEF);
      u_tool.xfer(0, 0, 8'hF0, rf, rd);
      `CHK(rf, 1'b1)
      u_tool.xfer(2, 0, 8'h00, rf, rd);
      `CHK(rf, 1'b1)
      u_tool.xfer(3, 1, 8'h00, rf, rd);
      `CHK(rf, 1'b1)
      u_tool.xfer(1, 0, 8'h00, rf, rd);
      `CHK(rd, 8'hF1)
      summarize();
   end
endmodule
